/* File: pkg/exc_seq_pkg.sv */
// constants shared by the exception sequencer and its vector encoder
// assumes a 32-bit core on one 25 MHz clock, registers reached over apb
package exc_seq_pkg;
   // apb register byte offsets
   localparam logic [11:0] sr_off = 12'h000;
   localparam logic [11:0] sp_off = 12'h004;
   localparam logic [11:0] vbr_off = 12'h008;
   localparam logic [11:0] stat_off = 12'h00c;
   // reset values
   localparam logic [15:0] sr_reset = 16'h2700;
   localparam logic [31:0] sp_reset = 32'h0000_0000;
   localparam logic [11:0] vbr_reset = 12'h000;
   // status word bit positions
   localparam int trace_bit = 15;
   localparam int priv_bit = 13;
   localparam int master_bit = 12;
   localparam int ipl_lsb = 8;
   localparam int ipl_msb = 10;
   // vector base: low bits not implemented
   localparam int vbr_lsb = 20;
   // exception kinds presented by the core
   localparam logic [3:0] kind_access = 4'h0;
   localparam logic [3:0] kind_address = 4'h1;
   localparam logic [3:0] kind_illegal = 4'h2;
   localparam logic [3:0] kind_priv = 4'h3;
   localparam logic [3:0] kind_trace = 4'h4;
   localparam logic [3:0] kind_line_a = 4'h5;
   localparam logic [3:0] kind_line_f = 4'h6;
   localparam logic [3:0] kind_debug = 4'h7;
   localparam logic [3:0] kind_format = 4'h8;
   localparam logic [3:0] kind_trap = 4'h9;
   localparam logic [3:0] kind_irq = 4'ha;
   // access fault causes
   localparam logic [1:0] cause_fetch = 2'h0;
   localparam logic [1:0] cause_read = 2'h1;
   localparam logic [1:0] cause_write = 2'h2;
   localparam logic [1:0] cause_protect = 2'h3;
   // fault status codes
   localparam logic [3:0] fs_none = 4'h0;
   localparam logic [3:0] fs_fetch = 4'h4;
   localparam logic [3:0] fs_read = 4'hc;
   localparam logic [3:0] fs_write = 4'h8;
   localparam logic [3:0] fs_protect = 4'h9;
   // vector numbers
   localparam logic [7:0] vec_access = 8'h02;
   localparam logic [7:0] vec_address = 8'h03;
   localparam logic [7:0] vec_illegal = 8'h04;
   localparam logic [7:0] vec_priv = 8'h08;
   localparam logic [7:0] vec_trace = 8'h09;
   localparam logic [7:0] vec_line_a = 8'h0a;
   localparam logic [7:0] vec_line_f = 8'h0b;
   localparam logic [7:0] vec_debug = 8'h0c;
   localparam logic [7:0] vec_format = 8'h0e;
   localparam logic [7:0] vec_spurious = 8'h18;
   localparam logic [7:0] vec_trap0 = 8'h20;
   localparam int vec_count = 256;
   localparam int table_bytes = 1024;
   // frame geometry
   localparam logic [3:0] format_base = 4'h4;
   localparam logic [31:0] pc_slot = 32'h0000_0004;
   localparam logic [31:0] fv_slot = 32'h0000_0008;
endpackage

/* File: src/exc_vector_calc.sv */
// internal vector encoder: vector number, fault status, pc choice
// assumes kind codes from the package; purely combinational
module exc_vector_calc (
   input wire logic [3:0] kind,
   input wire logic [3:0] trap_num,
   input wire logic [1:0] cause,
   output logic [7:0] vector,
   output logic [3:0] fault_status,
   output logic use_fault_pc
);
   import exc_seq_pkg::*;

   // one vector per kind except trap, no bus cycle involved
   always_comb begin
      vector = vec_spurious;
      use_fault_pc = 1'b1;
      case (kind) // RULE3
         kind_access: vector = vec_access; // RULE12
         kind_address: vector = vec_address;
         kind_illegal: vector = vec_illegal;
         kind_priv: vector = vec_priv;
         kind_line_a: vector = vec_line_a;
         kind_line_f: vector = vec_line_f;
         kind_format: vector = vec_format;
         kind_trace: begin
            vector = vec_trace; // RULE13
            use_fault_pc = 1'b0;
         end
         kind_debug: begin
            vector = vec_debug;
            use_fault_pc = 1'b0;
         end
         kind_trap: begin
            vector = vec_trap0 + {4'h0, trap_num}; // RULE11
            use_fault_pc = 1'b0;
         end
         default: use_fault_pc = 1'b0; // interrupts take the next pc
      endcase
   end

   // fault status only means something for access and address errors
   always_comb begin
      fault_status = fs_none; // RULE16
      if (kind == kind_access || kind == kind_address) begin
         case (cause) // RULE17 RULE18
            cause_fetch: fault_status = fs_fetch;
            cause_read: fault_status = fs_read;
            cause_write: fault_status = fs_write;
            default: fault_status = fs_protect;
         endcase
      end
   end
endmodule

/* File: src/exc_sequencer.sv */
// exception sequencer: status update, vector, frame push, vector fetch
// assumes a memory port answering with mem_ack on the same clock, an
// apb master for the registers, and core inputs on the same clock
//
// How it works
// RULE1: save status word copy, then set supervisor and clear trace
// RULE2: interrupts also clear master state and load the priority mask
// RULE3: non-interrupt vectors come from the exception kind, no bus cycle
// RULE4: interrupts run an acknowledge cycle carrying level; peer returns vector
// RULE5: one stack pointer for all states; frame on four-byte aligned top
// RULE6: frame is two longwords: format/vector plus status, then the pc
// RULE7: handler address read from vector base plus four times vector
// RULE8: sequence ends once the handler's first opcode fetch is issued
// RULE9: table is 1024 bytes of 256 vectors, 64 up are user interrupts
// RULE10: autovectored levels one to seven use vectors 25 to 31, next pc
// RULE11: trap 0 to 15 use vectors 32 to 47, next pc saved
// RULE12: fault pc saved for vectors 2, 3, 4, 8, 10, 11, 14
// RULE13: next pc saved for 9, 12, 15, 24 and 64 to 255
// RULE14: interrupt sampling held off during a handler's first instruction
// RULE15: format 4 to 7 follows stack low bits; stack drops 8 to 11
// RULE16: fault status coded only for access and address errors
// RULE17: fault status 0100 on fetch error, 1100 on operand read
// RULE18: fault status 1000 on write error, 1001 on protected write
// RULE19: frame vector field holds internal or peripheral vector number
// RULE20: low twenty vector base bits read zero, table on 1 MB boundary
// RULE21: trace bit 15, supervisor 13, master 12, mask bits 10 to 8
// RULE22: return with format outside 4 to 7 raises a format error
// RULE23: four phases in strict order, one exception at a time
// RULE24: two aligned stores below the top, pc at the higher address
module exc_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // exception request from the core
   input wire logic exc_valid,
   input wire logic [3:0] exc_kind,
   input wire logic [3:0] exc_trap_num,
   input wire logic [1:0] exc_cause,
   input wire logic [2:0] exc_irq_level,
   input wire logic exc_autovec,
   input wire logic [31:0] exc_fault_pc,
   input wire logic [31:0] exc_next_pc,
   output logic exc_ready,
   // return-from-exception format check
   input wire logic rte_valid,
   input wire logic [31:0] rte_frame,
   input wire logic [31:0] rte_pc,
   output logic rte_ok,
   // memory master
   output logic mem_req,
   output logic mem_wr,
   output logic mem_interrupt_ack_cycle,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_err,
   // handler entry
   output logic handler_go,
   output logic [31:0] handler_pc,
   input wire logic first_instr_done,
   output logic irq_inhibit,
   output logic [15:0] status_word,
   output logic halted
);
   import exc_seq_pkg::*;

   typedef enum logic [2:0] {
      st_idle, st_status, st_vector, st_interrupt_ack_cycle, st_push_pc, st_push_fv,
      st_fetch, st_enter
   } seq_state_e;

   seq_state_e state;
   logic [31:0] stack_pointer_reg;
   logic [31:vbr_lsb] vector_base_reg;
   logic [15:0] saved_sr;
   logic [3:0] kind;
   logic [3:0] trap_num;
   logic [1:0] cause;
   logic [2:0] irq_level;
   logic autovec;
   logic [31:0] fault_pc;
   logic [31:0] next_pc;
   logic [7:0] vector;
   logic [3:0] fault_status_field;
   logic use_fault_pc;
   logic [7:0] last_vector;
   logic [3:0] last_format;
   logic [7:0] calc_vector;
   logic [3:0] calc_fs;
   logic calc_fault_pc;
   logic is_irq;
   logic [31:0] aligned_top;
   logic [3:0] format_field;
   logic [31:0] frame_pc;
   logic [31:0] frame_fv;
   logic [3:0] rte_format;
   logic rte_bad;
   logic start_exc;
   logic start_fmt;
   logic apb_wr;
   logic apb_rd;
   logic own_regs;

   exc_vector_calc u_calc (
      .kind(kind),
      .trap_num(trap_num),
      .cause(cause),
      .vector(calc_vector),
      .fault_status(calc_fs),
      .use_fault_pc(calc_fault_pc)
   );

   // frame geometry from the stack pointer at the time of the exception
   assign is_irq = (kind == kind_irq);
   assign aligned_top = {stack_pointer_reg[31:2], 2'b00}; // RULE5
   assign format_field = format_base + {2'b00, stack_pointer_reg[1:0]}; // RULE15
   assign frame_pc = use_fault_pc ? fault_pc : next_pc; // RULE12 RULE13
   // format, fs high, vector, fs low, then the saved status word
   assign frame_fv = {format_field, fault_status_field[3:2], vector,
      fault_status_field[1:0], saved_sr}; // RULE6 RULE19
   assign rte_format = rte_frame[31:28];
   assign rte_bad = (rte_format < format_base) ||
      (rte_format > format_base + 4'h3); // RULE22
   // requests only taken while idle: one exception at a time
   assign start_exc = (state == st_idle) && !halted && exc_valid; // RULE23
   assign start_fmt = (state == st_idle) && !halted && !exc_valid &&
      rte_valid && rte_bad; // RULE22
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   // software may not move the stack or status while a frame is built
   assign own_regs = (state != st_idle);

   // sequencer state, phases strictly in order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
      end else if (mem_req && mem_ack && mem_err) begin
         state <= st_idle; // fault during processing halts the core
      end else begin
         case (state) // RULE23
            st_idle: if (start_exc || start_fmt) state <= st_status;
            st_status: state <= is_irq ? st_interrupt_ack_cycle : st_vector;
            st_vector: state <= st_push_pc;
            st_interrupt_ack_cycle: if (mem_ack) state <= st_push_pc;
            st_push_pc: if (mem_ack) state <= st_push_fv;
            st_push_fv: if (mem_ack) state <= st_fetch;
            st_fetch: if (mem_ack) state <= st_enter;
            default: state <= st_idle;
         endcase
      end
   end

   // capture of the request so the core may move on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind <= kind_access;
         trap_num <= 4'h0;
         cause <= cause_fetch;
         irq_level <= 3'h0;
         autovec <= 1'b0;
         fault_pc <= 32'h0000_0000;
         next_pc <= 32'h0000_0000;
      end else if (start_exc) begin
         kind <= exc_kind;
         trap_num <= exc_trap_num;
         cause <= exc_cause;
         irq_level <= exc_irq_level;
         autovec <= exc_autovec;
         fault_pc <= exc_fault_pc;
         next_pc <= exc_next_pc;
      end else if (start_fmt) begin
         kind <= kind_format; // stacked pc points at the return itself
         fault_pc <= rte_pc;
         next_pc <= rte_pc;
      end
   end

   // status word: phase one, or a software write when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= sr_reset;
         saved_sr <= sr_reset;
      end else if (state == st_status) begin
         saved_sr <= status_word; // RULE1
         status_word[priv_bit] <= 1'b1; // RULE21
         status_word[trace_bit] <= 1'b0;
         if (is_irq) begin
            status_word[master_bit] <= 1'b0; // RULE2
            status_word[ipl_msb:ipl_lsb] <= irq_level;
         end
      end else if (apb_wr && !own_regs && paddr == sr_off) begin
         status_word <= pwdata[15:0];
      end
   end

   // vector number and fault status: phase two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector <= 8'h00;
         fault_status_field <= fs_none;
         use_fault_pc <= 1'b0;
      end else if (state == st_vector) begin
         vector <= calc_vector; // RULE3
         fault_status_field <= calc_fs;
         use_fault_pc <= calc_fault_pc;
      end else if (state == st_interrupt_ack_cycle && mem_ack) begin
         // autovector: level n maps onto 24 + n
         vector <= autovec ? vec_spurious + {5'h00, irq_level} // RULE10
            : mem_rdata[7:0]; // RULE4 RULE19
         fault_status_field <= fs_none; // RULE16
         use_fault_pc <= 1'b0; // RULE13
      end
   end

   // the single stack pointer: drops to the lower frame slot once pushed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_pointer_reg <= sp_reset;
      end else if (state == st_push_fv && mem_ack && !mem_err) begin
         stack_pointer_reg <= aligned_top - fv_slot; // RULE15
      end else if (apb_wr && !own_regs && paddr == sp_off) begin
         stack_pointer_reg <= pwdata;
      end
   end

   // vector base, only the top twelve bits exist
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_base_reg <= vbr_reset;
      end else if (apb_wr && !own_regs && paddr == vbr_off) begin
         vector_base_reg <= pwdata[31:vbr_lsb]; // RULE20
      end
   end

   // memory master: acknowledge cycle, two stores, one vector read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req <= 1'b0;
         mem_wr <= 1'b0;
         mem_interrupt_ack_cycle <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
      end else if (mem_req && !mem_ack) begin
         mem_req <= 1'b1; // hold the request until answered
      end else if (mem_req && mem_ack && mem_err) begin
         mem_req <= 1'b0;
         mem_wr <= 1'b0;
         mem_interrupt_ack_cycle <= 1'b0;
      end else if (state == st_status && is_irq) begin
         mem_req <= 1'b1; // RULE4
         mem_wr <= 1'b0;
         mem_interrupt_ack_cycle <= 1'b1;
         mem_addr <= {28'h0000_000, 1'b0, irq_level};
      end else if (state == st_vector ||
         (state == st_interrupt_ack_cycle && mem_ack)) begin
         mem_req <= 1'b1; // RULE24
         mem_wr <= 1'b1;
         mem_interrupt_ack_cycle <= 1'b0;
         mem_addr <= aligned_top - pc_slot;
         mem_wdata <= next_pc;
         if (state == st_vector && calc_fault_pc) begin
            mem_wdata <= fault_pc; // RULE12
         end
      end else if (state == st_push_pc && mem_ack) begin
         mem_req <= 1'b1; // RULE6
         mem_wr <= 1'b1;
         mem_addr <= aligned_top - fv_slot; // RULE24
         mem_wdata <= frame_fv;
      end else if (state == st_push_fv && mem_ack) begin
         mem_req <= 1'b1; // RULE7
         mem_wr <= 1'b0;
         mem_addr <= {vector_base_reg, 10'h000, vector, 2'b00}; // RULE9
      end else begin
         mem_req <= 1'b0;
         mem_wr <= 1'b0;
         mem_interrupt_ack_cycle <= 1'b0;
      end
   end

   // handler entry: first opcode fetch issued with the fetched vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         handler_go <= 1'b0;
         handler_pc <= 32'h0000_0000;
      end else begin
         handler_go <= (state == st_fetch) && mem_ack && !mem_err; // RULE8
         if (state == st_fetch && mem_ack) begin
            handler_pc <= mem_rdata; // RULE7
         end
      end
   end

   // interrupt sampling held off until the first instruction retires;
   // a new entry in the same cycle as the retire drops the hold for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_inhibit <= 1'b0;
      end else if (state == st_status) begin
         irq_inhibit <= 1'b1; // RULE14
      end else if (first_instr_done && state == st_idle) begin
         irq_inhibit <= 1'b0;
      end
   end

   // sequencer busy and handshake back to the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exc_ready <= 1'b0;
         rte_ok <= 1'b0;
      end else begin
         exc_ready <= (state == st_idle) && !start_exc && !start_fmt &&
            !halted;
         rte_ok <= (state == st_idle) && !halted && !exc_valid &&
            rte_valid && !rte_bad; // RULE22
      end
   end

   // fault while a frame is built is fatal until reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted <= 1'b0;
      end else if (mem_req && mem_ack && mem_err) begin
         halted <= 1'b1;
      end
   end

   // record of the last frame built, for software to inspect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_vector <= 8'h00;
         last_format <= 4'h0;
      end else if (state == st_push_pc && mem_ack) begin
         last_vector <= vector;
         last_format <= format_field;
      end
   end

   // apb read data, decoded in the setup phase so it is ready in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (paddr == sr_off) begin
            if (apb_rd) prdata <= {16'h0000, status_word};
         end else if (paddr == sp_off) begin
            if (apb_rd) prdata <= stack_pointer_reg;
         end else if (paddr == vbr_off) begin
            if (apb_rd) prdata <= {vector_base_reg, 20'h00000}; // RULE20
         end else if (paddr == stat_off) begin
            if (apb_rd) begin
               prdata <= {16'h0000, last_vector, last_format, 2'b00,
                  halted, own_regs};
            end
         end else begin
            pslverr <= 1'b1;
         end
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

   // zero wait states: every access completes in its first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end
endmodule

/* File: tb/exc_seq_chk_sva.sv */
// assertions on the exception sequencer's core, memory and handler ports
// assumes the bench holds request fields steady until the handler starts
module exc_seq_chk
   import exc_seq_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic exc_valid,
   input logic [3:0] exc_kind,
   input logic [2:0] exc_irq_level,
   input logic exc_ready,
   input logic rte_valid,
   input logic [31:0] rte_frame,
   input logic rte_ok,
   input logic mem_req,
   input logic mem_wr,
   input logic mem_interrupt_ack_cycle,
   input logic [31:0] mem_addr,
   input logic [31:0] mem_rdata,
   input logic mem_ack,
   input logic handler_go,
   input logic [31:0] handler_pc,
   input logic irq_inhibit,
   input logic [15:0] status_word
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // entry raises supervisor, drops trace and holds off sampling
   entry_status_a:
      assert property (exc_valid && exc_ready |-> ##[1:3]
         (status_word[priv_bit] && !status_word[trace_bit] && irq_inhibit))
      else $error("entry status not set");
   irq_mask_a:
      assert property (exc_valid && exc_ready && exc_kind == kind_irq
         |-> ##[1:3] (status_word[ipl_msb:ipl_lsb] == exc_irq_level
         && !status_word[master_bit]))
      else $error("interrupt mask not loaded");
   // the sequence is long, so a quick handler start is a slip
   busy_take_a:
      assert property (exc_valid && exc_ready |=>
         (!exc_ready && !handler_go) [*4])
      else $error("not busy after taking request");
   // one cycle in the entry state, then idle shows on exc_ready
   ready_back_a:
      assert property (handler_go |=> !handler_go ##1 exc_ready)
      else $error("no idle after handler start");
   handler_pc_a:
      assert property (handler_go |-> handler_pc == $past(mem_rdata)
         && $past(mem_ack) && !$past(mem_wr) && !$past(mem_interrupt_ack_cycle))
      else $error("handler address not the fetched vector");
   vec_addr_a:
      assert property (mem_req && !mem_wr && !mem_interrupt_ack_cycle |->
         mem_addr[19:10] == 10'h000 && mem_addr[1:0] == 2'h0)
      else $error("vector read outside the table");
   interrupt_ack_cycle_addr_a:
      assert property (mem_req && mem_interrupt_ack_cycle |->
         !mem_wr && mem_addr[2:0] == exc_irq_level)
      else $error("acknowledge cycle without level");
   store_align_a:
      assert property (mem_req && mem_wr |-> mem_addr[1:0] == 2'h0)
      else $error("frame store not aligned");
   req_hold_a:
      assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped early");
   rte_good_a:
      assert property (rte_valid && exc_ready && !exc_valid
         && rte_frame[31:30] == 2'h1 |=> rte_ok)
      else $error("valid frame not accepted");
   rte_bad_a:
      assert property (rte_valid && exc_ready && !exc_valid
         && rte_frame[31:30] != 2'h1 |=> !rte_ok ##[0:2] !exc_ready)
      else $error("bad frame format not refused");
endmodule

bind exc_sequencer exc_seq_chk chk_u (.*);

/* File: tb/exc_mem_model.sv */
// memory and interrupting peripheral behind the sequencer's memory port
// assumes one request at a time, held until acknowledged
module exc_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic mem_interrupt_ack_cycle,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic mem_err
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_n = 0, cnt = 0, wn = 0;
   logic fail = 1'b0;
   logic [7:0] irq_vec = 8'h00;
   logic [31:0] wa [2], wd [2];

   // answers after wait_n cycles; an idle data bus toggles so stale
   // values never look valid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 0;
      end else if (mem_req && !mem_ack && cnt < wait_n) begin
         cnt <= cnt + 1;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && !mem_ack) begin
         cnt <= 0;
         mem_ack <= 1'b1;
         mem_err <= fail;
         mem_rdata <= mem_interrupt_ack_cycle ? {24'h0, irq_vec} : ~mem_addr;
         if (mem_wr) begin
            wa[wn[0]] <= mem_addr;
            wd[wn[0]] <= mem_wdata;
            wn <= wn + 1;
         end
      end else begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* File: tb/cpu_exception_sequencer_tb.sv */
// self-checking bench for the exception sequencer over apb
// assumes exc_mem_model on the memory port and the bound checker
module cpu_exception_sequencer_tb import exc_seq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, sp = 32'h0000_8000, q;
   logic pready, pslverr, e, exc_ready, rte_ok, mem_req, mem_wr, mem_interrupt_ack_cycle;
   logic exc_valid = 1'b0, exc_autovec = 1'b0, rte_valid = 1'b0;
   logic [3:0] exc_kind = 4'h0, exc_trap_num = 4'h0;
   logic [1:0] exc_cause = 2'h0;
   logic [2:0] exc_irq_level = 3'h0;
   logic [31:0] exc_fault_pc = 32'h1000, exc_next_pc = 32'h1002;
   logic [31:0] rte_frame = 32'h0, rte_pc = 32'h2000;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, handler_pc;
   logic mem_ack, mem_err, handler_go, irq_inhibit, halted;
   logic first_instr_done = 1'b0;
   logic [15:0] status_word;
   int num_errors = 0, samples_checked = 0, cycles = 0;

   exc_sequencer dut_u (.*);
   exc_mem_model mem_u (.*);

   // 25 mhz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test;
      end
   end

   task automatic stop_test;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one exception; pcs picks fault pc, next pc or a bad return frame
   task automatic exc(input logic [3:0] k, input logic [7:0] ev,
      input logic [1:0] pcs, input logic [3:0] n = 4'h1,
      input logic [3:0] fs = 4'h0, input logic [2:0] lv = 3'h0,
      input logic av = 1'b0);
      logic [31:0] top, pc;
      sp = sp + 32'h105;
      top = sp & 32'hffff_fffc;
      pc = pcs == 2'h0 ? 32'h1000 : pcs == 2'h1 ? 32'h1002 : 32'h2000;
      apb(1'b1, sp_off, sp);
      apb(1'b1, sr_off, 32'h9015);
      mem_u.wn = 0;
      mem_u.irq_vec = av ? ~ev : ev;
      exc_kind <= k;
      exc_trap_num <= n;
      exc_cause <= n[1:0];
      exc_irq_level <= lv;
      exc_autovec <= av;
      rte_frame <= 32'h2000_0000;
      rte_valid <= pcs == 2'h2;
      exc_valid <= pcs != 2'h2;
      @(posedge pclk);
      exc_valid <= 1'b0;
      rte_valid <= 1'b0;
      do @(posedge pclk); while (handler_go !== 1'b1);
      chk(handler_pc, ~(32'h1230_0000 | {22'h0, ev, 2'h0}));
      chk({16'h0, status_word}, k == kind_irq ? {19'h4, lv, 8'h15} : 32'h3015);
      chk({31'h0, irq_inhibit}, 32'h1);
      chk(mem_u.wa[0], top - 32'h4);
      chk(mem_u.wd[0], pc);
      chk(mem_u.wa[1], top - 32'h8);
      chk(mem_u.wd[1], {4'h4 + {2'h0, sp[1:0]}, fs[3:2], ev, fs[1:0], 16'h9015});
      apb(1'b0, sp_off, 32'h0);
      chk(q, top - 32'h8);
      first_instr_done <= 1'b1;
      @(posedge pclk);
      first_instr_done <= 1'b0;
      @(posedge pclk);
      chk({31'h0, irq_inhibit}, 32'h0);
   endtask

   // reset, registers, every vector kind, return check, fault-on-fault
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sr_off, 32'h0);
      chk(q, 32'h2700);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, vbr_off, 32'h1234_5678);
      apb(1'b0, vbr_off, 32'h0);
      chk(q, 32'h1230_0000);
      exc(kind_access, 8'h02, 2'h0, 4'h0, 4'h4);
      exc(kind_access, 8'h02, 2'h0, 4'h1, 4'hc);
      exc(kind_access, 8'h02, 2'h0, 4'h2, 4'h8);
      exc(kind_access, 8'h02, 2'h0, 4'h3, 4'h9);
      exc(kind_address, 8'h03, 2'h0, 4'h0, 4'h4);
      exc(kind_illegal, 8'h04, 2'h0);
      exc(kind_priv, 8'h08, 2'h0);
      exc(kind_trace, 8'h09, 2'h1);
      exc(kind_line_a, 8'h0a, 2'h0);
      exc(kind_line_f, 8'h0b, 2'h0);
      exc(kind_debug, 8'h0c, 2'h1);
      exc(kind_format, 8'h0e, 2'h0);
      exc(kind_trap, 8'h20, 2'h1, 4'h0);
      exc(kind_trap, 8'h2f, 2'h1, 4'hf);
      mem_u.wait_n = 3;
      exc(kind_irq, 8'h19, 2'h1, 4'h1, 4'h0, 3'h1, 1'b1);
      exc(kind_irq, 8'h1f, 2'h1, 4'h1, 4'h0, 3'h7, 1'b1);
      exc(kind_irq, 8'h40, 2'h1, 4'h1, 4'h0, 3'h3);
      exc(kind_irq, 8'hff, 2'h1, 4'h1, 4'h0, 3'h5);
      exc(kind_irq, 8'h0f, 2'h1, 4'h1, 4'h0, 3'h2);
      exc(kind_irq, 8'h18, 2'h1, 4'h1, 4'h0, 3'h4);
      mem_u.wait_n = 0;
      exc(kind_format, 8'h0e, 2'h2);
      rte_frame <= 32'h4000_2015;
      rte_valid <= 1'b1;
      @(posedge pclk);
      rte_valid <= 1'b0;
      @(posedge pclk);
      chk({31'h0, rte_ok}, 32'h1);
      mem_u.fail = 1'b1;
      exc_kind <= kind_illegal;
      exc_valid <= 1'b1;
      @(posedge pclk);
      exc_valid <= 1'b0;
      repeat (30) @(posedge pclk);
      chk({30'h0, halted, exc_ready}, 32'h2);
      stop_test;
   end
endmodule
